// file: src/asip_pkg.sv
// constants, types and decode helpers for the analog shared input port
package asip_pkg;

  // widths
  localparam int LINES = 16;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int CHAN_W = 5;

  // register offsets on the extension peripheral bus
  localparam logic [15:0] PIN_DATA_OFS = 16'hc380;
  localparam logic [15:0] DIG_OFF_OFS = 16'hc382;

  // reset values
  localparam logic [15:0] DIG_OFF_RST = 16'h0000;
  localparam logic [15:0] RDATA_RST = 16'h0000;

  // enable bit positions in the system-level configuration registers
  localparam int EXT_EN_BIT = 2;
  localparam int XPER_SEL_BIT = 3;

  // converter channel fed by port line 0
  localparam logic [4:0] CHAN_BASE = 5'h10;

  // level read back from a line whose digital input is off
  localparam logic DISABLED_LEVEL = 1'b0;

  // byte enables of a whole-word access
  localparam logic [1:0] BE_WORD = 2'h3;

  // bus answer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACK = 2'b01,
    ST_ERR = 2'b10
  } asip_state_t;

  // address compare, used for each register
  function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // converter channel number for a port line
  function automatic logic [4:0] chan_of(input logic [3:0] line);
    chan_of = CHAN_BASE + {1'b0, line};
  endfunction

endpackage

// file: src/asip_bus_decode.sv
// address decode and access legality for the port registers
`timescale 1ns/1ps
module asip_bus_decode (
  // access request
  input wire logic [15:0] addr,
  input wire logic [1:0] be,
  input wire logic bitop,
  // system enables
  input wire logic [15:0] sys_cfg,
  input wire logic [15:0] xper_sel,
  // decode results
  output logic hit_pin,
  output logic hit_off,
  output logic legal,
  output logic port_en
);

  // both enable bits must be set
  assign port_en = sys_cfg[asip_pkg::EXT_EN_BIT] & xper_sel[asip_pkg::XPER_SEL_BIT]; // RULE1

  // register selects
  assign hit_pin = asip_pkg::reg_hit(addr, asip_pkg::PIN_DATA_OFS);
  assign hit_off = asip_pkg::reg_hit(addr, asip_pkg::DIG_OFF_OFS);

  // whole words only, no bit set or clear cycles
  assign legal = (be == asip_pkg::BE_WORD) & ~bitop; // RULE2

endmodule

// file: src/asip_line_sampler.sv
// per-line digital sampling with input buffer disable
`timescale 1ns/1ps
module asip_line_sampler (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // pins and line control
  input wire logic [15:0] pin_in,
  input wire logic [15:0] dig_off,
  // sampled levels
  output logic [15:0] pin_data
);

  logic [15:0] samp_nxt;
  logic [15:0] samp_r;

  // disabled lines read a fixed level
  genvar g;
  generate
    for (g = 0; g < asip_pkg::LINES; g++) begin : g_line
      always_comb begin
        samp_nxt[g] = dig_off[g] ? asip_pkg::DISABLED_LEVEL : pin_in[g]; // RULE9 RULE10
      end
    end
  endgenerate

  // pin levels carry no reset value
  always_ff @(posedge core_clk) begin
    samp_r <= samp_nxt; // RULE11 RULE3
  end

  assign pin_data = samp_r;

  // checks on the sampled levels
  a_masked_line: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE10
    (dig_off != 16'h0000) |=> ((pin_data & $past(dig_off)) == 16'h0000))
    else $error("disabled line reads non-zero");
  a_sample_level: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE3
    (dig_off == 16'h0000) |=> (pin_data == $past(pin_in)))
    else $error("enabled line level not sampled");

endmodule

// file: src/asip_port.sv
// analog shared input port: pin data and digital disable registers
// Operation
// (RULE1) Port works only with both system enable bits 2 and 3 set.
// (RULE2) Registers take whole-word access only; bit set or clear refused.
// (RULE3) Sixteen input-only lines; pin data read returns sampled levels.
// (RULE4) No output latch and no direction control; lines never driven.
// (RULE5) Writes to pin data are taken and discarded without effect.
// (RULE6) Line y feeds converter channel sixteen plus y.
// (RULE7) Analog path always connected, independent of port registers.
// (RULE8) Digital disable register: one RW bit per line, resets zero.
// (RULE9) Disable bit 0 keeps input buffer on; 1 turns it off.
// (RULE10) Disabled line reads a constant zero in pin data.
// (RULE11) Pin data has no reset value; it reflects sampled levels.
`timescale 1ns/1ps
module asip_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // system enables
  input wire logic [15:0] sys_cfg,
  input wire logic [15:0] xper_sel,
  // extension peripheral bus
  input wire logic epb_req,
  input wire logic epb_we,
  input wire logic [15:0] epb_addr,
  input wire logic [1:0] epb_be,
  input wire logic epb_bitop,
  input wire logic [15:0] epb_wdata,
  output logic [15:0] epb_rdata,
  output logic epb_ack,
  output logic epb_err,
  // port pins
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  // input buffer control
  output logic [15:0] schmitt_en,
  // converter side
  output logic [31:16] adc_an,
  output logic [4:0] adc_chan_lo,
  output logic [4:0] adc_chan_hi
);

  asip_pkg::asip_state_t state_r;
  asip_pkg::asip_state_t state_nxt;
  logic [15:0] dig_off_r;
  logic [15:0] dig_off_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [15:0] pin_data;
  logic hit_pin;
  logic hit_off;
  logic legal;
  logic port_en;
  logic take;
  logic ok;

  // decode of the current request
  asip_bus_decode u_dec (
    .addr(epb_addr),
    .be(epb_be),
    .bitop(epb_bitop),
    .sys_cfg(sys_cfg),
    .xper_sel(xper_sel),
    .hit_pin(hit_pin),
    .hit_off(hit_off),
    .legal(legal),
    .port_en(port_en)
  );

  // line sampling
  asip_line_sampler u_samp (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in(pin_in),
    .dig_off(dig_off_r),
    .pin_data(pin_data)
  );

  // request taken only when idle
  assign take = epb_req & (state_r == asip_pkg::ST_IDLE);
  assign ok = port_en & legal; // RULE1 RULE2

  // next state, register and read data
  always_comb begin
    state_nxt = state_r;
    dig_off_nxt = dig_off_r;
    rdata_nxt = rdata_r;
    case (state_r)
      asip_pkg::ST_IDLE: begin
        if (take) begin
          if (!ok) begin
            state_nxt = asip_pkg::ST_ERR; // RULE1 RULE2
            rdata_nxt = asip_pkg::RDATA_RST;
          end else begin
            state_nxt = asip_pkg::ST_ACK;
            if (epb_we) begin
              if (hit_off) begin
                dig_off_nxt = epb_wdata; // RULE8
              end
              // pin data writes are dropped here
              rdata_nxt = rdata_r; // RULE5
            end else if (hit_pin) begin
              rdata_nxt = pin_data; // RULE3
            end else if (hit_off) begin
              rdata_nxt = dig_off_r; // RULE8
            end else begin
              rdata_nxt = asip_pkg::RDATA_RST;
            end
          end
        end
      end
      asip_pkg::ST_ACK: begin
        state_nxt = asip_pkg::ST_IDLE;
      end
      asip_pkg::ST_ERR: begin
        state_nxt = asip_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = asip_pkg::ST_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= asip_pkg::ST_IDLE;
      dig_off_r <= asip_pkg::DIG_OFF_RST; // RULE8
      rdata_r <= asip_pkg::RDATA_RST;
    end else begin
      state_r <= state_nxt;
      dig_off_r <= dig_off_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // bus answer
  assign epb_rdata = rdata_r;
  assign epb_ack = (state_r == asip_pkg::ST_ACK);
  assign epb_err = (state_r == asip_pkg::ST_ERR);

  // input only: nothing ever drives a pin
  assign pin_out = 16'h0000; // RULE4
  assign pin_oe = 16'h0000; // RULE4

  // buffer on while disable bit is clear
  assign schmitt_en = ~dig_off_r; // RULE9

  // analog path straight from the pins
  assign adc_an = pin_in; // RULE6 RULE7

  // channel range served by this port
  assign adc_chan_lo = asip_pkg::chan_of(4'h0); // RULE6
  assign adc_chan_hi = asip_pkg::chan_of(4'hf); // RULE6

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_ack_after_req: assert property ( // RULE1
    (take && ok) |=> (epb_ack && !epb_err) ##1 (!epb_ack && !epb_err))
    else $error("legal access not acknowledged once");
  a_refuse_partial: assert property ( // RULE2
    (take && (epb_be != 2'h3 || epb_bitop)) |=> (epb_err && !epb_ack && $stable(dig_off_r)))
    else $error("partial or bit access not refused");
  a_dis_blocked: assert property ( // RULE1
    (take && !port_en) |=> (epb_err && $stable(dig_off_r) && epb_rdata == 16'h0000))
    else $error("access while disabled had effect");
  a_pin_write_drop: assert property ( // RULE5
    (take && ok && epb_we && hit_pin) |=> ($stable(dig_off_r) && $stable(epb_rdata)))
    else $error("pin data write changed state");
  a_off_write: assert property ( // RULE8
    (take && ok && epb_we && hit_off) |=> (dig_off_r == $past(epb_wdata)))
    else $error("disable register write lost");
  a_read_pin: assert property ( // RULE3
    (take && ok && !epb_we && hit_pin) |=> (epb_rdata == $past(pin_data)))
    else $error("pin read returns wrong level");
  a_no_drive: assert property ( // RULE4
    (pin_oe == 16'h0000) && (pin_out == 16'h0000))
    else $error("port line driven");
  a_reset_off: assert property (@(posedge core_clk) disable iff (1'b0) // RULE8
    !rst_n |=> (dig_off_r == 16'h0000 && schmitt_en == 16'hffff))
    else $error("disable register not cleared by reset");

endmodule

// file: bench/asip_pin_source.sv
// signal source standing on the port pins
`timescale 1ns/1ps
module asip_pin_source (
  // clock
  input wire logic core_clk,
  // level asked for by the bench
  input wire logic [15:0] level,
  // driven pin levels
  output logic [15:0] pin_in
);
  // pins follow the source one edge late, as an outside driver would
  always_ff @(posedge core_clk) begin
    pin_in <= level;
  end
endmodule

// file: bench/analog_shared_input_port_bench.sv
// self-checking bench for the analog shared input port
`timescale 1ns/1ps
module analog_shared_input_port_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] sys_cfg = 16'h0004;
  logic [15:0] xper_sel = 16'h0008;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [1:0] be = 2'h3;
  logic bitop = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] level = 16'h0000;
  logic [15:0] pin_in, rdata, pin_out, pin_oe, schmitt_en, p, d;
  logic [31:16] adc_an;
  logic [4:0] chan_lo, chan_hi;
  logic ack, err;
  logic [31:0] seed = 32'h8c2c;
  int fail_count = 0;
  int total_checks = 0;

  // clock
  always #5 core_clk = ~core_clk;

  asip_pin_source u_asip_pin_source (.core_clk(core_clk), .level(level), .pin_in(pin_in));

  asip_port u_asip_port (.core_clk(core_clk), .rst_n(rst_n), .sys_cfg(sys_cfg), .xper_sel(xper_sel),
    .epb_req(req), .epb_we(we), .epb_addr(addr), .epb_be(be), .epb_bitop(bitop), .epb_wdata(wdata),
    .epb_rdata(rdata), .epb_ack(ack), .epb_err(err), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .schmitt_en(schmitt_en), .adc_an(adc_an), .adc_chan_lo(chan_lo), .adc_chan_hi(chan_hi));

  // xorshift source of stimulus
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  // pin data expected: disabled lines read zero
  function automatic logic [15:0] exp_pin(input logic [15:0] pins, input logic [15:0] off);
    return pins & ~off;
  endfunction

  // value compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus access: request held until the answer is sampled, answer due one cycle after the taking edge
  task automatic bus(input logic w, input logic [15:0] a, input logic [1:0] b, input logic bo,
                     input logic [15:0] wd, input logic e, input logic [15:0] xd);
    int n;
    @(posedge core_clk);
    req <= 1'b1;
    we <= w;
    addr <= a;
    be <= b;
    bitop <= bo;
    wdata <= wd;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 4);
    chk(16'(n), 16'h0001);
    chk(16'(ack), 16'(!e));
    chk(16'(err), 16'(e));
    if (!w || e) chk(rdata, xd);
    // release on the edge that samples the answer high; a busy block ignores the request there
    @(posedge core_clk);
    req <= 1'b0;
  endtask

  // verdict
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // watchdog
  initial begin
    #50000;
    fail_count++;
    results();
  end

  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(schmitt_en, 16'hffff);
    chk(pin_oe, 16'h0000);
    chk(pin_out, 16'h0000);
    chk({11'h000, chan_lo}, 16'h0010);
    chk({11'h000, chan_hi}, 16'h001f);
    bus(1'b0, asip_pkg::DIG_OFF_OFS, 2'h3, 1'b0, 16'h0000, 1'b0, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      p = (i == 0) ? 16'hffff : rnd();
      d = (i == 0) ? 16'h0000 : ((i == 1) ? 16'hffff : rnd());
      bus(1'b1, asip_pkg::DIG_OFF_OFS, 2'h3, 1'b0, d, 1'b0, 16'h0000);
      chk(schmitt_en, ~d);
      level <= p;
      repeat (3) @(posedge core_clk);
      #1;
      chk(adc_an, p);
      bus(1'b0, asip_pkg::PIN_DATA_OFS, 2'h3, 1'b0, 16'h0000, 1'b0, exp_pin(p, d));
      bus(1'b1, asip_pkg::PIN_DATA_OFS, 2'h3, 1'b0, ~d, 1'b0, 16'h0000);
      bus(1'b0, asip_pkg::DIG_OFF_OFS, 2'h3, 1'b0, 16'h0000, 1'b0, d);
    end
    for (int k = 0; k < 4; k++) begin
      sys_cfg <= (k == 2) ? 16'hfffb : 16'h0004;
      xper_sel <= (k == 3) ? 16'hfff7 : 16'h0008;
      bus(1'b1, asip_pkg::DIG_OFF_OFS, (k == 0) ? 2'h1 : 2'h3, k == 1, 16'h5a5a, 1'b1, 16'h0000);
      sys_cfg <= 16'h0004;
      xper_sel <= 16'h0008;
      bus(1'b0, asip_pkg::DIG_OFF_OFS, 2'h3, 1'b0, 16'h0000, 1'b0, d);
    end
    bus(1'b0, 16'hc384, 2'h3, 1'b0, 16'h0000, 1'b0, 16'h0000);
    // second reset in mid-run clears the disable register again
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(schmitt_en, 16'hffff);
    bus(1'b0, asip_pkg::DIG_OFF_OFS, 2'h3, 1'b0, 16'h0000, 1'b0, 16'h0000);
    results();
  end
endmodule
